// ### pkg/cpr_pkg.sv
// package of constants and types for the card parameter register
package cpr_pkg;

   // ************************************************************
   // register port
   // ************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] REG_USER   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_IMAGE0 = 4'h2;
   localparam logic [ADDR_W-1:0] REG_IMAGE1 = 4'h3;
   localparam logic [ADDR_W-1:0] REG_IMAGE2 = 4'h4;
   localparam logic [ADDR_W-1:0] REG_IMAGE3 = 4'h5;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;

   // config register field positions
   localparam int CFG_MODEL_LSB  = 0;
   localparam int CFG_RD_LO_LSB  = 4;
   localparam int CFG_RD_HI_LSB  = 8;
   localparam int CFG_WR_LO_LSB  = 12;
   localparam int CFG_WR_HI_LSB  = 16;
   // user register occupies bits 7:0 in image order
   localparam int USER_LSB       = 0;
   // status register field positions
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_CLOCK_BIT = 1;
   localparam int STAT_COPYL_BIT = 2;
   localparam int STAT_LEFT_LSB  = 8;

   // ************************************************************
   // fixed field values of the image
   // ************************************************************
   localparam logic [1:0]  LAYOUT_VERSION  = 2'h2;
   localparam logic [3:0]  SPEC_REVISION   = 4'h3;
   localparam logic [7:0]  ASYNC_ACCESS    = 8'h26;
   localparam logic [7:0]  CLOCKED_ACCESS  = 8'h01;
   localparam logic [7:0]  TRANSFER_RATE   = 8'h2a;
   localparam logic [11:0] COMMAND_CLASSES = 12'h0f5;
   localparam logic [3:0]  READ_BLOCK_SIZE = 4'h9;
   localparam logic        PARTIAL_READ    = 1'h0;
   localparam logic        WRITE_SPAN      = 1'h0;
   localparam logic        READ_SPAN       = 1'h0;
   localparam logic        DRIVER_STAGE    = 1'h0;
   localparam logic [4:0]  ERASE_SIZE_FACTOR      = 5'h1f;
   localparam logic [4:0]  ERASE_SIZE_SML  = 5'h00;
   localparam logic [4:0]  ERASE_SIZE_BIG  = 5'h07;
   localparam logic [4:0]  PROTECT_GROUP   = 5'h03;
   localparam logic        PROTECT_ENABLE  = 1'h1;
   localparam logic [1:0]  DEFAULT_ECC     = 2'h0;
   localparam logic [2:0]  WRITE_FACTOR    = 3'h4;
   localparam logic [3:0]  WRITE_BLOCK     = 4'h9;
   localparam logic        PARTIAL_WRITE   = 1'h0;
   localparam logic        END_BIT         = 1'h1;
   localparam logic [6:0]  CRC_POLY        = 7'h09;

   // capacity models: size field and multiplier
   localparam logic [2:0]  MODEL_32M  = 3'h0;
   localparam logic [2:0]  MODEL_64M  = 3'h1;
   localparam logic [2:0]  MODEL_128M = 3'h2;
   localparam logic [2:0]  MODEL_256M = 3'h3;
   localparam logic [2:0]  MODEL_512M = 3'h4;
   localparam logic [2:0]  MODEL_1G   = 3'h5;
   localparam logic [11:0] SIZE_7A7   = 12'h7a7;
   localparam logic [11:0] SIZE_F4F   = 12'hf4f;
   localparam logic [11:0] SIZE_3D3   = 12'h3d3;
   localparam logic [2:0]  FACTOR_3   = 3'h3;
   localparam logic [2:0]  FACTOR_6   = 3'h6;
   localparam logic [2:0]  FACTOR_7   = 3'h7;

   // reset values of the programmable storage, and the bit count loaded at transfer start
   localparam logic [2:0]  RST_MODEL   = 3'h0;
   localparam logic [2:0]  RST_CURRENT = 3'h4;
   localparam logic [7:0]  RST_USER    = 8'h40;
   localparam logic [6:0]  LAST_BIT    = 7'h7f;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic                wr;
      logic                rd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } cpr_bus_req_t;

   typedef struct packed {
      logic       fileGroup;
      logic       copyFlag;
      logic       permProtect;
      logic       tempProtect;
      logic [1:0] fileFormat;
      logic [1:0] eccCode;
   } cpr_user_t;

   typedef struct packed {
      logic [2:0] model;
      logic [2:0] readCurrentLowVolt;
      logic [2:0] readCurrentHighVolt;
      logic [2:0] writeCurrentLowVolt;
      logic [2:0] writeCurrentHighVolt;
   } cpr_cfg_t;

endpackage

// ### hdl/cpr_card_parameter_register.sv
// card parameter register: 128-bit image, programmable fields, serial out
`timescale 1ns/1ps
module cpr_card_parameter_register (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // register port
   input  wire cpr_pkg::cpr_bus_req_t      busReq,
   output logic [cpr_pkg::DATA_W-1:0]      rdData_r,
   // link from the host
   input  wire logic                       linkClk,
   // command logic side
   input  wire logic                       shiftStart,
   output logic                            serialOut_r,
   output logic                            shiftBusy_r,
   output logic                            shiftDone_r,
   output logic [127:0]                    image_r
);
   import cpr_pkg::*;

   // ************************************************************
   // checksum over the upper 120 bits
   // ************************************************************
   function automatic logic [6:0] crc7(input logic [119:0] d);
      logic [6:0] c;
      logic       fb;
      c = '0;
      for (int i = 119; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c  = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction

   // ************************************************************
   // programmable storage
   // ************************************************************
   cpr_cfg_t  cfg_r;
   cpr_cfg_t  cfg_nxt;
   cpr_user_t user_r;
   cpr_user_t user_nxt;
   logic      copyLocked_r;
   logic      copyLocked_nxt;
   cpr_user_t wrUser;

   assign wrUser = cpr_user_t'(busReq.wdata[USER_LSB +: 8]);

   always_comb begin
      cfg_nxt        = cfg_r;
      user_nxt       = user_r;
      copyLocked_nxt = copyLocked_r;
      if (busReq.wr && busReq.addr == REG_CONFIG) begin
         // models above the table are refused; old model stays
         if (busReq.wdata[CFG_MODEL_LSB +: 3] <= MODEL_1G) begin
            cfg_nxt.model = busReq.wdata[CFG_MODEL_LSB +: 3];
         end
         cfg_nxt.readCurrentLowVolt   =
            busReq.wdata[CFG_RD_LO_LSB +: 3];
         cfg_nxt.readCurrentHighVolt  =
            busReq.wdata[CFG_RD_HI_LSB +: 3];
         cfg_nxt.writeCurrentLowVolt  =
            busReq.wdata[CFG_WR_LO_LSB +: 3];
         cfg_nxt.writeCurrentHighVolt =
            busReq.wdata[CFG_WR_HI_LSB +: 3];
      end
      if (busReq.wr && busReq.addr == REG_USER) begin
         user_nxt.fileGroup   = wrUser.fileGroup;
         user_nxt.tempProtect = wrUser.tempProtect;
         user_nxt.fileFormat  = wrUser.fileFormat;
         user_nxt.eccCode     = wrUser.eccCode;
         // permanent protection can only ever be set
         user_nxt.permProtect = user_r.permProtect | wrUser.permProtect;
         // copy flag takes one write only, then is frozen
         if (!copyLocked_r) begin
            user_nxt.copyFlag = wrUser.copyFlag;
            copyLocked_nxt    = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r        <= '{RST_MODEL, RST_CURRENT, RST_CURRENT,
                           RST_CURRENT, RST_CURRENT};
         user_r       <= cpr_user_t'(RST_USER);
         copyLocked_r <= 1'b0;
      end else begin
         cfg_r        <= cfg_nxt;
         user_r       <= user_nxt;
         copyLocked_r <= copyLocked_nxt;
      end
   end

   // ************************************************************
   // image assembly
   // ************************************************************
   logic [11:0]  sizeField;
   logic [2:0]   sizeFactor;
   logic [4:0]   eraseSize;
   logic [119:0] body;
   logic [127:0] image_nxt;

   // capacity = (size+1) * 2^(factor+2) * 2^blockcode; factor < 8
   always_comb begin
      sizeField  = SIZE_7A7;
      sizeFactor = FACTOR_3;
      eraseSize  = ERASE_SIZE_BIG;
      unique case (cfg_r.model)
         MODEL_32M: begin
            sizeField  = SIZE_7A7;
            sizeFactor = FACTOR_3;
            eraseSize  = ERASE_SIZE_SML;
         end
         MODEL_64M: begin
            sizeField  = SIZE_F4F;
            sizeFactor = FACTOR_3;
            eraseSize  = ERASE_SIZE_SML;
         end
         MODEL_128M: begin
            sizeField  = SIZE_3D3;
            sizeFactor = FACTOR_6;
         end
         MODEL_256M: begin
            sizeField  = SIZE_7A7;
            sizeFactor = FACTOR_6;
         end
         MODEL_512M: begin
            sizeField  = SIZE_F4F;
            sizeFactor = FACTOR_6;
         end
         MODEL_1G: begin
            sizeField  = SIZE_F4F;
            sizeFactor = FACTOR_7;
         end
         default: begin
            sizeField  = SIZE_7A7;
            sizeFactor = FACTOR_3;
            eraseSize  = ERASE_SIZE_SML;
         end
      endcase
   end

   // fields listed from bit 127 downward
   always_comb begin
      body = {
         LAYOUT_VERSION,
         SPEC_REVISION,
         2'h0,
         ASYNC_ACCESS,
         CLOCKED_ACCESS,
         TRANSFER_RATE,
         COMMAND_CLASSES,
         READ_BLOCK_SIZE,
         PARTIAL_READ,
         WRITE_SPAN,
         READ_SPAN,
         DRIVER_STAGE,
         2'h0,
         sizeField,
         cfg_r.readCurrentLowVolt,
         cfg_r.readCurrentHighVolt,
         cfg_r.writeCurrentLowVolt,
         cfg_r.writeCurrentHighVolt,
         sizeFactor,
         eraseSize,
         ERASE_SIZE_FACTOR,
         PROTECT_GROUP,
         PROTECT_ENABLE,
         DEFAULT_ECC,
         WRITE_FACTOR,
         WRITE_BLOCK,
         PARTIAL_WRITE,
         5'h00,
         user_r
      };
      image_nxt = {body, crc7(body), END_BIT};
   end

   // ************************************************************
   // link clock sampling
   // ************************************************************
   logic linkSync1_r;
   logic linkSync2_r;
   logic linkPrev_r;
   logic linkFall;

   always_ff @(posedge clk) begin
      if (rst) begin
         linkSync1_r <= 1'b0;
         linkSync2_r <= 1'b0;
         linkPrev_r  <= 1'b0;
      end else begin
         linkSync1_r <= linkClk;
         linkSync2_r <= linkSync1_r;
         linkPrev_r  <= linkSync2_r;
      end
   end

   // bits change after the host's falling edge, host samples on rising
   assign linkFall = linkPrev_r & ~linkSync2_r;

   // ************************************************************
   // serial shifter
   // ************************************************************
   typedef enum logic {CPR_IDLE, CPR_SHIFT} cpr_state_t;

   cpr_state_t   state_r;
   cpr_state_t   state_nxt;
   logic [127:0] shift_r;
   logic [127:0] shift_nxt;
   logic [6:0]   left_r;
   logic [6:0]   left_nxt;
   logic         serial_nxt;
   logic         busy_nxt;
   logic         done_nxt;

   always_comb begin
      state_nxt  = state_r;
      shift_nxt  = shift_r;
      left_nxt   = left_r;
      serial_nxt = serialOut_r;
      busy_nxt   = shiftBusy_r;
      done_nxt   = 1'b0;
      unique case (state_r)
         CPR_IDLE: begin
            serial_nxt = 1'b1;
            if (shiftStart) begin
               // snapshot, so later writes cannot tear a transfer
               shift_nxt  = image_r;
               serial_nxt = image_r[127];
               left_nxt   = LAST_BIT;
               busy_nxt   = 1'b1;
               state_nxt  = CPR_SHIFT;
            end
         end
         CPR_SHIFT: begin
            if (linkFall) begin
               if (left_r == 7'h00) begin
                  serial_nxt = 1'b1;
                  busy_nxt   = 1'b0;
                  done_nxt   = 1'b1;
                  state_nxt  = CPR_IDLE;
               end else begin
                  shift_nxt  = {shift_r[126:0], 1'b0};
                  serial_nxt = shift_r[126];
                  left_nxt   = left_r - 7'h01;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r     <= CPR_IDLE;
         shift_r     <= '0;
         left_r      <= '0;
         serialOut_r <= 1'b1;
         shiftBusy_r <= 1'b0;
         shiftDone_r <= 1'b0;
         image_r     <= '0;
      end else begin
         state_r     <= state_nxt;
         shift_r     <= shift_nxt;
         left_r      <= left_nxt;
         serialOut_r <= serial_nxt;
         shiftBusy_r <= busy_nxt;
         shiftDone_r <= done_nxt;
         image_r     <= image_nxt;
      end
   end

   // ************************************************************
   // register read port
   // ************************************************************
   logic [DATA_W-1:0] rd_nxt;

   always_comb begin
      rd_nxt = '0;
      if (busReq.rd) begin
         unique case (busReq.addr)
            REG_CONFIG: begin
               rd_nxt[CFG_MODEL_LSB +: 3] = cfg_r.model;
               rd_nxt[CFG_RD_LO_LSB +: 3] = cfg_r.readCurrentLowVolt;
               rd_nxt[CFG_RD_HI_LSB +: 3] = cfg_r.readCurrentHighVolt;
               rd_nxt[CFG_WR_LO_LSB +: 3] = cfg_r.writeCurrentLowVolt;
               rd_nxt[CFG_WR_HI_LSB +: 3] = cfg_r.writeCurrentHighVolt;
            end
            REG_USER:   rd_nxt[USER_LSB +: 8] = user_r;
            REG_IMAGE0: rd_nxt = image_r[31:0];
            REG_IMAGE1: rd_nxt = image_r[63:32];
            REG_IMAGE2: rd_nxt = image_r[95:64];
            REG_IMAGE3: rd_nxt = image_r[127:96];
            REG_STATUS: begin
               rd_nxt[STAT_BUSY_BIT]     = shiftBusy_r;
               rd_nxt[STAT_CLOCK_BIT]    = linkSync2_r;
               rd_nxt[STAT_COPYL_BIT]    = copyLocked_r;
               rd_nxt[STAT_LEFT_LSB +: 7] = left_r;
            end
            default:    rd_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_r <= '0;
      end else begin
         rdData_r <= rd_nxt;
      end
   end

endmodule

// ### verif/cpr_card_parameter_register_chk.sv
// port checker for the card parameter register
`timescale 1ns/1ps
module cpr_card_parameter_register_chk (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // register port
   input wire cpr_pkg::cpr_bus_req_t busReq,
   input wire logic [31:0]           rdData_r,
   // link and shifter
   input wire logic                  linkClk,
   input wire logic                  shiftStart,
   input wire logic                  serialOut_r,
   input wire logic                  shiftBusy_r,
   input wire logic                  shiftDone_r,
   input wire logic [127:0]          image_r
);
   import cpr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ******
   // sequences
   // ******
   // image is only assembled one edge after reset lets go
   sequence imgValid;
      !$past(rst);
   endsequence
   sequence startTaken;
      shiftStart && !shiftBusy_r;
   endsequence
   sequence doneEnd;
      shiftDone_r ##1 !shiftDone_r;
   endsequence
   // ******
   // image fields
   // ******
   layout_fixed_a:
      assert property (imgValid |-> image_r[127:120] == {2'h2, 4'h3, 2'h0})
      else $error("layout or revision field wrong");
   access_fixed_a:
      assert property (imgValid |-> image_r[119:96] == 24'h26012a)
      else $error("access or rate byte wrong");
   class_fixed_a:
      assert property (imgValid |-> image_r[95:76] == {12'h0f5, 4'h9, 4'h0})
      else $error("class mask, block code or flags wrong");
   model_pair_a:
      assert property (imgValid |-> image_r[49:47] inside {3'h3, 3'h6, 3'h7}
         && ((image_r[49:47] == 3'h3) == (image_r[46:42] == 5'h00)))
      else $error("size multiplier or erase size wrong");
   end_bit_a:
      assert property (imgValid |-> image_r[0] && image_r[20:16] == 5'h00)
      else $error("end bit or reserved bits wrong");
   // ******
   // register port and shifter
   // ******
   image_read_a:
      assert property (busReq.rd && busReq.addr == REG_IMAGE3
         |=> rdData_r == $past(image_r[127:96]))
      else $error("top image word read wrong");
   read_idle_a:
      assert property (!$past(busReq.rd) |-> rdData_r == '0)
      else $error("read data not zero without read");
   start_load_a:
      assert property (startTaken
         |=> shiftBusy_r && serialOut_r == $past(image_r[127]))
      else $error("transfer did not start with top bit");
   idle_high_a:
      assert property (!shiftBusy_r |-> serialOut_r)
      else $error("serial line not high when idle");
   done_pulse_a:
      assert property (!$past(rst) && $fell(shiftBusy_r) |-> doneEnd)
      else $error("done pulse missing or too long");
endmodule
bind cpr_card_parameter_register cpr_card_parameter_register_chk i_chk (
   .clk(clk), .rst(rst), .busReq(busReq), .rdData_r(rdData_r),
   .linkClk(linkClk), .shiftStart(shiftStart), .serialOut_r(serialOut_r),
   .shiftBusy_r(shiftBusy_r), .shiftDone_r(shiftDone_r), .image_r(image_r)
);

// ### verif/cpr_host_model.sv
// host model: clocks the link in frames and samples the card data
`timescale 1ns/1ps
module cpr_host_model (
   // frame request from the bench
   input wire logic     go,
   // card link
   output logic         linkClk,
   input wire logic     serialOut_r,
   // captured frame
   output logic [127:0] frame
);
   // read latency the host budgets at its 800 ns link period
   localparam real LATENCY_NS = 1.5e6 + 100 * 800.0;
   initial begin
      linkClk = 1'b0;
      frame = '0;
      forever begin
         @(posedge go);
         // offset keeps link edges clear of the system clock edges
         #30;
         repeat (128) begin
            #400 linkClk = 1'b1;
            frame = {frame[126:0], serialOut_r};
            #400 linkClk = 1'b0;
         end
      end
   end
endmodule

// ### verif/cpr_card_parameter_register_tb.sv
// self-checking bench for the card parameter register
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("FAIL %0t got %h want %h", $time, a, b); end end
module cpr_card_parameter_register_tb;
   import cpr_pkg::*;
   logic         clk, rst, linkClk, shiftStart, go;
   logic         serialOut_r, shiftBusy_r, shiftDone_r;
   cpr_bus_req_t busReq;
   logic [31:0]  rdData_r;
   logic [127:0] image_r, frame;
   int           n_fail = 0, n_compared = 0, expM = 0;
   logic [11:0]  expCur = 12'h924;
   logic [7:0]   expUser = 8'h40;
   localparam logic [11:0] SZ [6] = '{12'h7a7, 12'hf4f, 12'h3d3,
                                      12'h7a7, 12'hf4f, 12'hf4f};
   localparam logic [2:0]  MU [6] = '{3'h3, 3'h3, 3'h6, 3'h6, 3'h6, 3'h7};

   cpr_card_parameter_register i_dut (
      .clk(clk), .rst(rst), .busReq(busReq), .rdData_r(rdData_r),
      .linkClk(linkClk), .shiftStart(shiftStart), .serialOut_r(serialOut_r),
      .shiftBusy_r(shiftBusy_r), .shiftDone_r(shiftDone_r), .image_r(image_r)
   );
   cpr_host_model i_host (
      .go(go), .linkClk(linkClk), .serialOut_r(serialOut_r), .frame(frame)
   );

   // ******
   // expectations
   // ******
   function automatic logic [127:0] expImg(input int m, input logic [11:0] c,
                                           input logic [7:0] u);
      logic [127:0] v;
      logic [6:0]   crc;
      logic         fb;
      v = {2'h2, 4'h3, 2'h0, 8'h26, 8'h01, 8'h2a, 12'h0f5, 4'h9, 4'h0, 2'h0,
           SZ[m], c, MU[m], (m < 2) ? 5'h00 : 5'h07, 5'h1f, 5'h03, 1'h1,
           2'h0, 3'h4, 4'h9, 1'h0, 5'h00, u, 8'h01};
      crc = '0;
      for (int i = 127; i >= 8; i--) begin
         fb = v[i] ^ crc[6];
         crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
      v[7:1] = crc;
      return v;
   endfunction
   function automatic logic [31:0] cfgWord(input int m, input logic [11:0] c);
      return {13'h0, c[2:0], 1'b0, c[5:3], 1'b0, c[8:6], 1'b0, c[11:9],
              1'b0, 3'(m)};
   endfunction

   // ******
   // bus and report
   // ******
   task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      busReq <= '0;
   endtask
   task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      busReq <= '0;
      @(negedge clk);
      d = rdData_r;
   endtask
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chkAll();
      logic [31:0]  d;
      logic [127:0] e;
      e = expImg(expM, expCur, expUser);
      rdReg(REG_CONFIG, d);
      `CHK(d, cfgWord(expM, expCur))
      for (int w = 0; w < 4; w++) begin
         rdReg(REG_IMAGE0 + 4'(w), d);
         `CHK(d, e[32*w +: 32])
      end
   endtask

   // ******
   // scenarios
   // ******
   task automatic tReset();
      logic [31:0] d;
      rdReg(REG_USER, d);
      `CHK(d, 32'h40)
      chkAll();
   endtask
   // model codes 6 and 7 are refused, current codes are still taken
   task automatic tModels();
      for (int k = 0; k < 8; k++) begin
         expCur = {3'(k), ~3'(k), 3'(k), ~3'(k)};
         expM = (k < 6) ? k : expM;
         wrReg(REG_CONFIG, cfgWord(k, expCur));
         chkAll();
      end
   endtask
   task automatic tUser();
      logic [31:0] d;
      wrReg(REG_USER, 32'h0);
      rdReg(REG_STATUS, d);
      `CHK(d[2], 1'b1)
      wrReg(REG_USER, 32'hff);
      rdReg(REG_USER, d);
      `CHK(d, 32'hbf)
      wrReg(REG_USER, 32'h0);
      expUser = 8'h20;
      chkAll();
   endtask
   task automatic tReadOnly();
      logic [31:0] d;
      wrReg(REG_IMAGE3, 32'h0);
      wrReg(4'hf, 32'hffffffff);
      rdReg(4'hf, d);
      `CHK(d, 32'h0)
      chkAll();
   endtask
   // poke: a start while busy and a model change must not touch the frame
   task automatic doShift(input logic [127:0] e, input bit poke);
      int i;
      @(posedge clk);
      shiftStart <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      shiftStart <= 1'b0;
      go <= 1'b0;
      if (poke) begin
         repeat (20) @(posedge clk);
         shiftStart <= 1'b1;
         @(posedge clk);
         shiftStart <= 1'b0;
         wrReg(REG_CONFIG, cfgWord(1, expCur));
      end
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (shiftDone_r !== 1'b1 && i < 1200);
      if (i >= 1200) begin
         n_fail++;
         $display("FAIL %0t transfer never ended", $time);
         final_report();
      end
      `CHK(frame, e)
   endtask
   task automatic tShift();
      doShift(expImg(expM, expCur, expUser), 1'b1);
      expM = 1;
      doShift(expImg(expM, expCur, expUser), 1'b0);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      busReq = '0;
      shiftStart = 1'b0;
      go = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      tReset();
      tModels();
      tUser();
      tReadOnly();
      tShift();
      final_report();
   end
endmodule
